//--- hdl/led_map.vh
// Purpose: Constants for the two-wire LED driver register block.
// Assumes: 40 MHz system clock; serial bus at most 400 kHz.
// Notes:   Definitions only, no logic.
//
// Operation
// - Answer only target address byte A8h.
// - Write-only target, no read data path.
// - Serial clock up to 400 kHz works.
// - Sample data while serial clock high.
// - Start is data falling while clock high.
// - Matching address acknowledged on ninth pulse.
// - Register address byte acknowledged, loads pointer.
// - Data byte acknowledged, written at pointer.
// - Stop is data rising while clock high.
// - Pointer increments during each data acknowledge.
// - Map: 00 shutdown, 01-12 duty, 13-17.
// - Shutdown bit D0, zero means shutdown.
// - Duty value sets on-time value/256.
// - Enable bits D5:D0, channel 1 lowest.
// - Shadowed writes copied by update write.
// - Reset register write restores all defaults.
// - Software shutdown forces all outputs off.
// - Hardware shutdown input low forces off.
// - Shutdown never alters register contents.
`ifndef LED_MAP_VH
`define LED_MAP_VH

`define LED_TARGET_ADDR    8'hA8
`define LED_NUM_CH         18

// Register offsets
`define LED_REG_SHUTDOWN   8'h00
`define LED_REG_DUTY_FIRST 8'h01
`define LED_REG_DUTY_LAST  8'h12
`define LED_REG_EN_LOW     8'h13
`define LED_REG_EN_MID     8'h14
`define LED_REG_EN_HIGH    8'h15
`define LED_REG_COMMIT     8'h16
`define LED_REG_DEFAULTS   8'h17

// Field positions and reset values
`define LED_SHUTDOWN_BIT   0
`define LED_EN_MSB         5
`define LED_SHUTDOWN_RST   1'b0
`define LED_DUTY_RST       8'h00
`define LED_EN_RST         6'h00

// Timing
`define LED_CLK_KHZ        40000
`define LED_SCL_MAX_KHZ    400
`define LED_SCL_HALF_CYC   (`LED_CLK_KHZ / `LED_SCL_MAX_KHZ / 2)
`define LED_PWM_DIV_CYC    8'h04
`define LED_BYTE_BITS      4'h8

`endif

//--- hdl/pin_sync.v
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Inputs idle high.
// Notes:   First stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_n_in,
  // Pins
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- hdl/pwm_channel.v
// Purpose: One channel: shadow duty, active duty and modulated output.
// Assumes: Strobes are one-cycle pulses from the register decoder.
// Notes:   Output is registered.
`timescale 1ns/1ps
`default_nettype none
`include "led_map.vh"
module pwm_channel (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_n_in,
  // Register access
  input  wire       wr_in,
  input  wire [7:0] wr_data_in,
  input  wire       commit_in,
  input  wire       clear_in,
  // Modulation
  input  wire [7:0] pwm_count_in,
  input  wire       enable_in,
  input  wire       run_in,
  output reg        channel_on_bit_out
);
  reg [7:0] shadow_q;
  reg [7:0] active_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shadow_q           <= `LED_DUTY_RST;
      active_q           <= `LED_DUTY_RST;
      channel_on_bit_out <= 1'b0;
    end else begin
      if (clear_in) begin
        shadow_q <= `LED_DUTY_RST;
        active_q <= `LED_DUTY_RST;
      end else begin
        if (wr_in) begin
          shadow_q <= wr_data_in;
        end
        if (commit_in) begin
          active_q <= shadow_q;
        end
      end
      // Duty n gives n of 256 counts on; zero is fully off
      channel_on_bit_out <= run_in && enable_in
                            && (pwm_count_in < active_q);
    end
  end
endmodule
`default_nettype wire

//--- hdl/led_driver_top.v
// Purpose: Write-only two-wire target and 18-channel PWM register block.
// Assumes: Bus pins sampled at 40 MHz; serial clock at most 400 kHz.
// Notes:   Data line is open drain; only low is ever driven.
`timescale 1ns/1ps
`default_nettype none
`include "led_map.vh"
module led_driver_top (
  // Clock and reset
  input  wire        CLOCK_IN,
  input  wire        ARST_N_IN,
  // Two-wire bus
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE_OUT,
  // Shutdown pin
  input  wire        HARD_POWERDOWN_N_IN,
  // Channel outputs
  output wire [17:0] LED_CHANNEL_OUTPUTS_OUT
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RECV = 2'b01;
  localparam ST_ACK  = 2'b10;

  localparam PH_ADDR = 2'b00;
  localparam PH_REG  = 2'b01;
  localparam PH_DATA = 2'b10;

  // Duty register select for one channel
  function chan_sel;
    input [7:0] addr;
    input integer idx;
    begin
      chan_sel = (addr == (`LED_REG_DUTY_FIRST + idx[7:0]));
    end
  endfunction

  // Enable register select for one six-channel group
  function en_grp_sel;
    input [7:0]   addr;
    input integer grp;
    begin
      en_grp_sel = (addr == (`LED_REG_EN_LOW + grp[7:0]));
    end
  endfunction

  // Phase after an acknowledge; the data phase repeats for bursts
  function [1:0] next_phase;
    input [1:0] ph;
    begin
      case (ph)
        PH_ADDR: next_phase = PH_REG;
        default: next_phase = PH_DATA;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  reg  [1:0] rst_sync_q;
  wire       rst_n;

  always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions
  wire [1:0] bus_s;
  wire       scl_s;
  wire       sda_s;
  wire       hard_powerdown_n;
  reg        scl_d_q;
  reg        sda_d_q;

  // Both bus pins share one delay so their order is kept
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync_bus (
    .clk_in   (CLOCK_IN),
    .rst_n_in (rst_n),
    .async_in ({SCL_IN, SDA_IN}),
    .sync_out (bus_s)
  );

  pin_sync #(
    .WIDTH (1)
  ) u_pin_sync_pd (
    .clk_in   (CLOCK_IN),
    .rst_n_in (rst_n),
    .async_in (HARD_POWERDOWN_N_IN),
    .sync_out (hard_powerdown_n)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  always @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // Sync lag is three clocks, far below the shortest clock half period
  wire scl_rise  = scl_s && !scl_d_q;
  wire scl_fall  = !scl_s && scl_d_q;
  wire start_det = scl_s && scl_d_q && sda_d_q && !sda_s;
  wire stop_det  = scl_s && scl_d_q && !sda_d_q && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Serial receiver
  reg [1:0] state_q;
  reg [1:0] phase_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg       ack_oe_q;
  reg       wr_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;

  // Byte boundary is the clock fall after the eighth bit
  wire      byte_done  = scl_fall && (bit_cnt_q == `LED_BYTE_BITS);
  wire      addr_match = (shift_q == `LED_TARGET_ADDR);

  always @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      phase_q   <= PH_ADDR;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      ack_oe_q  <= 1'b0;
      wr_q      <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (start_det) begin
        state_q   <= ST_RECV;
        phase_q   <= PH_ADDR;
        bit_cnt_q <= 4'h0;
        ack_oe_q  <= 1'b0;
      end else if (stop_det) begin
        state_q  <= ST_IDLE;
        ack_oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RECV: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (byte_done) begin
              bit_cnt_q <= 4'h0;
              if (phase_q == PH_ADDR && !addr_match) begin
                // Reads carry a different byte, so are never answered
                state_q <= ST_IDLE;
              end else begin
                state_q  <= ST_ACK;
                ack_oe_q <= 1'b1;
                if (phase_q == PH_REG) begin
                  ptr_q <= shift_q;
                end
                if (phase_q == PH_DATA) begin
                  wr_q      <= 1'b1;
                  wr_addr_q <= ptr_q;
                  wr_data_q <= shift_q;
                  ptr_q     <= ptr_q + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              ack_oe_q <= 1'b0;
              state_q  <= ST_RECV;
              phase_q  <= next_phase(phase_q);
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign SDA_OUT    = 1'b0;
  assign SDA_OE_OUT = ack_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Register file
  // Addresses above the map match nothing and change nothing
  wire wr_shutdown = wr_q && (wr_addr_q == `LED_REG_SHUTDOWN);
  wire wr_commit   = wr_q && (wr_addr_q == `LED_REG_COMMIT);
  wire wr_clear    = wr_q && (wr_addr_q == `LED_REG_DEFAULTS);

  reg         soft_powerdown_n_q;
  wire [17:0] en_active;
  wire [17:0] duty_wr;

  // Shutdown bit acts at once; only duty and enables wait for commit
  always @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      soft_powerdown_n_q <= `LED_SHUTDOWN_RST;
    end else if (wr_clear) begin
      soft_powerdown_n_q <= `LED_SHUTDOWN_RST;
    end else if (wr_shutdown) begin
      soft_powerdown_n_q <= wr_data_q[`LED_SHUTDOWN_BIT];
    end
  end

  // One six-bit group per register, lowest bit the lowest channel
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_en_grp
      wire      grp_wr = wr_q && en_grp_sel(wr_addr_q, k);
      reg [5:0] shadow_q;
      reg [5:0] active_q;

      always @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
          shadow_q <= `LED_EN_RST;
          active_q <= `LED_EN_RST;
        end else if (wr_clear) begin
          shadow_q <= `LED_EN_RST;
          active_q <= `LED_EN_RST;
        end else begin
          if (grp_wr) begin
            shadow_q <= wr_data_q[`LED_EN_MSB:0];
          end
          if (wr_commit) begin
            active_q <= shadow_q;
          end
        end
      end

      assign en_active[6*k+5:6*k] = active_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Modulation counter
  reg  [7:0] div_q;
  reg  [7:0] pwm_count_q;
  wire       pwm_tick = (div_q == `LED_PWM_DIV_CYC - 8'h01);

  // Divider: one-cycle step enable for the counter
  always @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (pwm_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // No reload, so every period is exactly 256 steps
  always @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pwm_count_q <= 8'h00;
    end else if (pwm_tick) begin
      pwm_count_q <= pwm_count_q + 8'h01;
    end
  end

  // Shutdown only gates outputs; registers keep their contents
  wire run_d = soft_powerdown_n_q && hard_powerdown_n;
  reg  run_q;

  // One flop so every channel sees a shutdown change on the same edge
  always @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `LED_NUM_CH; g = g + 1) begin : g_chan
      assign duty_wr[g] = wr_q && chan_sel(wr_addr_q, g);

      pwm_channel u_chan (
        .clk_in             (CLOCK_IN),
        .rst_n_in           (rst_n),
        .wr_in              (duty_wr[g]),
        .wr_data_in         (wr_data_q),
        .commit_in          (wr_commit),
        .clear_in           (wr_clear),
        .pwm_count_in       (pwm_count_q),
        .enable_in          (en_active[g]),
        .run_in             (run_q),
        .channel_on_bit_out (LED_CHANNEL_OUTPUTS_OUT[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

//--- testbench/led_monitor.sv
// Purpose: Port checker for the LED driver top.
// Assumes: Serial clock holds each level for 4 clocks or more.
// Notes:   Attached to every instance of the top by bind.
`timescale 1ns/1ps
`default_nettype none
module led_monitor (
  input wire        CLOCK_IN,
  input wire        ARST_N_IN,
  input wire        SCL_IN,
  input wire        SDA_IN,
  input wire        SDA_OUT,
  input wire        SDA_OE_OUT,
  input wire        HARD_POWERDOWN_N_IN,
  input wire [17:0] LED_CHANNEL_OUTPUTS_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  ////////////////////////////////////////
  AST_SDA_LOW_ONLY: assert property (SDA_OUT == 1'b0)
    else $error("data pin value not low");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !ARST_N_IN |-> !SDA_OE_OUT && LED_CHANNEL_OUTPUTS_OUT == 18'h0)
    else $error("outputs active in reset");
  AST_HARD_OFF: assert property (
    !HARD_POWERDOWN_N_IN [*5] |-> LED_CHANNEL_OUTPUTS_OUT == 18'h0)
    else $error("channel on in hardware shutdown");
  AST_ACK_HOLD: assert property (
    SCL_IN && $past(SCL_IN) && $past(SDA_OE_OUT) |-> SDA_OE_OUT)
    else $error("acknowledge dropped while clock high");
  AST_ACK_LEN: assert property (
    $rose(SDA_OE_OUT) |-> SDA_OE_OUT [*4] ##[1:8] !SDA_OE_OUT)
    else $error("acknowledge length wrong");
  AST_ACK_QUIET: assert property (
    SCL_IN [*8] |-> !$rose(SDA_OE_OUT))
    else $error("acknowledge without clock fall");
  AST_PWM_ON_MIN: assert property (
    $rose(LED_CHANNEL_OUTPUTS_OUT[0]) |=> LED_CHANNEL_OUTPUTS_OUT[0] [*3])
    else $error("on time shorter than one step");
  AST_PWM_OFF_MIN: assert property (
    $fell(LED_CHANNEL_OUTPUTS_OUT[17]) |=> !LED_CHANNEL_OUTPUTS_OUT[17] [*3])
    else $error("off time shorter than one step");
endmodule
bind led_driver_top led_monitor u_mon (
  .CLOCK_IN               (CLOCK_IN),
  .ARST_N_IN              (ARST_N_IN),
  .SCL_IN                 (SCL_IN),
  .SDA_IN                 (SDA_IN),
  .SDA_OUT                (SDA_OUT),
  .SDA_OE_OUT             (SDA_OE_OUT),
  .HARD_POWERDOWN_N_IN    (HARD_POWERDOWN_N_IN),
  .LED_CHANNEL_OUTPUTS_OUT(LED_CHANNEL_OUTPUTS_OUT)
);
`default_nettype wire

//--- testbench/i2c_ctrl.sv
// Purpose: Behavioural two-wire bus controller.
// Assumes: Data wire pulled up; device pulls low via its enable.
// Notes:   Serial clock stands high between frames; write only.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl (
  input  wire logic oe_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic drv_low;
  // Released wire floats to the pull-up level
  assign sda_out = !(drv_low || oe_in);
  initial begin
    scl_out = 1'b1;
    drv_low = 1'b0;
  end
  ////////////////////////////////////////
  task automatic pulse(output logic s);
    #50;
    scl_out = 1'b1;
    #90;
    s = sda_out;
    #10;
    scl_out = 1'b0;
    #50;
  endtask
  task automatic start_cond();
    #100;
    drv_low = 1'b1;
    #100;
    scl_out = 1'b0;
    #50;
  endtask
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      drv_low = !v[i];
      pulse(s);
    end
    drv_low = 1'b0;
    pulse(s);
    ack = !s;
  endtask
  task automatic stop_cond();
    drv_low = 1'b1;
    #50;
    scl_out = 1'b1;
    #100;
    drv_low = 1'b0;
    #1300;
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the LED driver top.
// Assumes: Controller model drives the serial pins.
// Notes:   On-time counted over one whole 1024-cycle period.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk;
  logic        arst_n;
  logic        hard_n;
  logic        scl;
  logic        sda;
  logic        oe;
  logic [17:0] leds;
  int          checks;
  int          n_mismatch;
  led_driver_top u_led_driver_top (
    .CLOCK_IN               (clk),
    .ARST_N_IN              (arst_n),
    .SCL_IN                 (scl),
    .SDA_IN                 (sda),
    .SDA_OUT                (),
    .SDA_OE_OUT             (oe),
    .HARD_POWERDOWN_N_IN    (hard_n),
    .LED_CHANNEL_OUTPUTS_OUT(leds)
  );
  i2c_ctrl u_i2c_ctrl (
    .oe_in  (oe),
    .scl_out(scl),
    .sda_out(sda)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] q[$], input logic ok);
    logic a;
    u_i2c_ctrl.start_cond();
    foreach (q[i]) begin
      u_i2c_ctrl.send_byte(q[i], a);
      chk({11'h0, a}, {11'h0, ok});
      if (!a) break;
    end
    u_i2c_ctrl.stop_cond();
  endtask
  // Middle channels summed: any of them on is a fault here
  task automatic measure(input logic [11:0] e0, input logic [11:0] e17);
    logic [11:0] c0;
    logic [11:0] c1;
    logic [11:0] c17;
    c0 = 12'h0;
    c1 = 12'h0;
    c17 = 12'h0;
    repeat (1024) begin
      @(negedge clk);
      c0 = c0 + {11'h0, leds[0]};
      c1 = c1 + {11'h0, |leds[16:1]};
      c17 = c17 + {11'h0, leds[17]};
    end
    chk(c0, e0);
    chk(c1, 12'h0);
    chk(c17, e17);
  endtask
  task automatic complete_run();
    $display("counts: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    hard_n = 1'b1;
    checks = 0;
    n_mismatch = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    measure(12'h0, 12'h0);
    $display("test defaults done");
    xfer('{8'hA6, 8'h00, 8'h01}, 1'b0);
    xfer('{8'hA9, 8'h00}, 1'b0);
    $display("test address done");
    xfer('{8'hA8, 8'h00, 8'h01}, 1'b1);
    xfer('{8'hA8, 8'h01, 8'h40, 8'h50}, 1'b1);
    measure(12'h0, 12'h0);
    xfer('{8'hA8, 8'h12, 8'h20, 8'h01, 8'h00, 8'h20, 8'h5A}, 1'b1);
    measure(12'h100, 12'h080);
    $display("test burst done");
    xfer('{8'hA8, 8'h18, 8'hFF}, 1'b1);
    measure(12'h100, 12'h080);
    xfer('{8'hA8, 8'h00, 8'h00}, 1'b1);
    measure(12'h0, 12'h0);
    xfer('{8'hA8, 8'h00, 8'h01}, 1'b1);
    measure(12'h100, 12'h080);
    $display("test soft shutdown done");
    hard_n <= 1'b0;
    repeat (8) @(posedge clk);
    measure(12'h0, 12'h0);
    hard_n <= 1'b1;
    repeat (8) @(posedge clk);
    measure(12'h100, 12'h080);
    $display("test hard shutdown done");
    xfer('{8'hA8, 8'h17, 8'h33}, 1'b1);
    xfer('{8'hA8, 8'h00, 8'h01}, 1'b1);
    xfer('{8'hA8, 8'h16, 8'h00}, 1'b1);
    measure(12'h0, 12'h0);
    $display("test defaults restore done");
    complete_run();
  end
  // Tests need about 0.31 ms; over six times that means a hang
  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
